// [srcc_top.sv]
// Reset sources, reset flags, boot vector, wake-up delay and core-clock divider
// Behaviour
// - Reset pin function follows reset pin enable.
// - Only power-up overrides the pin enable.
// - Six sources each put device into reset.
// - One readable flag per reset source.
// - Writing zero clears a flag.
// - Power-on sets power-on and brownout, clears rest.
// - Other resets set own flag, keep others.
// - Fetch starts at zero or boot address.
// - Boot address is vector byte, low zero.
// - Boot on break, boot status, forced programming.
// - Crystal sources wait 992 cycles plus 60us.
// - Other sources wait 224 cycles plus 60us.
// - Core clock is oscillator divided, up to 510.
// - Divider change applies without pausing execution.
// - Every reset clears the low-power bit.
// - Clock output gives core clock halved.
// - No clock output when crystal clocks timer.
// - In reset crystal port input-only, no pull-up.
// - Crystal input is port pin for internal oscillators, unless crystal clocks timer.
module srcc_top #(
  parameter int WAKE_XTAL  = srcc_pkg::WAKE_XTAL_TOTAL,
  parameter int WAKE_OTHER = srcc_pkg::WAKE_OTHER_TOTAL
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        RST_PIN_N,
  input  wire logic        BROWNOUT_DET,
  input  wire logic        ISP_FORCE,
  input  wire logic        WATCHDOG_TIMEOUT,
  input  wire logic        SOFTWARE_RESET_REQ,
  input  wire logic        BREAK_DETECT,
  input  wire logic        RESET_PIN_ENABLE_BIT,
  input  wire logic [2:0]  CLOCK_SOURCE,
  input  wire logic        TIMER_USES_CRYSTAL,
  input  wire logic [7:0]  BOOT_STATUS,
  input  wire logic [7:0]  BOOT_VECTOR,
  input  wire logic [7:0]  SFR_ADDR,
  input  wire logic [7:0]  SFR_WDATA,
  input  wire logic        SFR_WR,
  input  wire logic        SFR_RD,
  output logic      [7:0]  SFR_RDATA,
  output logic             CORE_RESET_N,
  output logic             CORE_CLOCK_EN,
  output logic      [15:0] FETCH_ADDR,
  output logic             LOW_POWER_CLOCK,
  output logic             DIVIDED_CLOCK_OUT,
  output logic             DIVIDED_CLOCK_OE,
  output logic             CRYSTAL_INPUT_IS_PORT,
  output logic             PORT3_INPUT_ONLY,
  output logic             PORT3_PULLUP_EN
);

  localparam int NS = srcc_pkg::NUM_SOURCES;

  // Pin synchronisers
  logic pin_n_s1;
  logic pin_n_s2;
  logic bod_s1;
  logic bod_s2;
  logic isp_s1;
  logic isp_s2;

  // Sequencer and reset bookkeeping
  srcc_pkg::srcc_state_t state;
  logic [srcc_pkg::WAKE_CNT_W-1:0] wake_cnt;
  logic                            power_up;
  logic                            isp_at_power_up;
  logic [NS-1:0]                   reset_source;
  logic [NS-1:0]                   src_event;
  logic                            pin_reset;
  logic                            any_reset;
  logic                            crystal_source;
  logic                            divided_clock_output_allowed;
  logic                            boot_select;

  // Registers
  logic [7:0] power_control;
  logic [7:0] clock_divider;
  logic [7:0] aux_one;
  logic [7:0] clock_out_ctrl;

  // Divider
  logic [8:0] div_cnt;
  logic [8:0] div_limit;
  logic       core_clock_tick;
  logic       sfr_write_ok;

  // Two flops on each pin before any logic looks at it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_n_s1 <= 1'b1;
      pin_n_s2 <= 1'b1;
      bod_s1   <= 1'b0;
      bod_s2   <= 1'b0;
      isp_s1   <= 1'b0;
      isp_s2   <= 1'b0;
    end else begin
      pin_n_s1 <= RST_PIN_N;
      pin_n_s2 <= pin_n_s1;
      bod_s1   <= BROWNOUT_DET;
      bod_s2   <= bod_s1;
      isp_s1   <= ISP_FORCE;
      isp_s2   <= isp_s1;
    end
  end

  // Pin acts as reset during power-up or when enabled, else plain input
  assign pin_reset = ~pin_n_s2 & (power_up | RESET_PIN_ENABLE_BIT);

  // Live reset requests; power-on comes through the asynchronous reset
  always_comb begin
    src_event                        = '0;
    src_event[srcc_pkg::SRC_PIN]      = pin_reset;
    src_event[srcc_pkg::SRC_SOFTWARE] = SOFTWARE_RESET_REQ;
    src_event[srcc_pkg::SRC_WATCHDOG] = WATCHDOG_TIMEOUT;
    src_event[srcc_pkg::SRC_BREAK]    = BREAK_DETECT;
    src_event[srcc_pkg::SRC_BROWNOUT] = bod_s2;
  end

  assign any_reset = |src_event;

  // Crystal selections and clock-output availability
  assign crystal_source = (CLOCK_SOURCE == srcc_pkg::CSRC_XTAL_LOW) ||
                          (CLOCK_SOURCE == srcc_pkg::CSRC_XTAL_MED) ||
                          (CLOCK_SOURCE == srcc_pkg::CSRC_XTAL_HIGH);
  assign divided_clock_output_allowed = ~crystal_source & ~TIMER_USES_CRYSTAL;

  // Reset source flags; a hardware set wins over a software clear
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_flag
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          reset_source[gi] <= srcc_pkg::RST_RESET_SOURCE[gi];
        end else if (src_event[gi]) begin
          reset_source[gi] <= 1'b1;
        end else if (sfr_write_ok && SFR_ADDR == srcc_pkg::ADDR_RESET_SOURCE &&
                     !SFR_WDATA[gi]) begin
          reset_source[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Power-up window ends when the first wake-up delay completes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      power_up        <= 1'b1;
      isp_at_power_up <= 1'b0;
    end else if (power_up) begin
      isp_at_power_up <= isp_s2;
      if (state == srcc_pkg::ST_WAKE && wake_cnt == '0) begin
        power_up <= 1'b0;
      end
    end
  end

  // Reset sequencer: hold, wake-up delay, run
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state    <= srcc_pkg::ST_RESET;
      wake_cnt <= '0;
    end else if (any_reset) begin
      state    <= srcc_pkg::ST_RESET;
      wake_cnt <= '0;
    end else begin
      case (state)
        srcc_pkg::ST_RESET: begin
          state <= srcc_pkg::ST_WAKE;
          if (crystal_source) begin
            wake_cnt <= srcc_pkg::WAKE_CNT_W'(WAKE_XTAL - 1);
          end else begin
            wake_cnt <= srcc_pkg::WAKE_CNT_W'(WAKE_OTHER - 1);
          end
        end
        srcc_pkg::ST_WAKE: begin
          if (wake_cnt == '0) begin
            state <= srcc_pkg::ST_RUN;
          end else begin
            wake_cnt <= wake_cnt - 1'b1;
          end
        end
        srcc_pkg::ST_RUN: begin
          state <= srcc_pkg::ST_RUN;
        end
        default: begin
          state <= srcc_pkg::ST_RESET;
        end
      endcase
    end
  end

  // Core is released one edge after the wake-up delay expires
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CORE_RESET_N <= 1'b0;
    end else begin
      CORE_RESET_N <= (state == srcc_pkg::ST_RUN) && !any_reset;
    end
  end

  // Boot address choice
  assign boot_select = reset_source[srcc_pkg::SRC_BREAK] |
                       BOOT_STATUS[srcc_pkg::BOOT_STATUS_VECTOR_POS] |
                       isp_at_power_up;

  // Fetch address latched while the core is held
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      FETCH_ADDR <= srcc_pkg::FETCH_ZERO;
    end else if (state != srcc_pkg::ST_RUN) begin
      if (boot_select) begin
        FETCH_ADDR <= {BOOT_VECTOR, srcc_pkg::BOOT_LOW_BYTE};
      end else begin
        FETCH_ADDR <= srcc_pkg::FETCH_ZERO;
      end
    end
  end

  // Software may only write while the core runs
  assign sfr_write_ok = SFR_WR && (state == srcc_pkg::ST_RUN);

  // Control registers, all returned to defaults by any reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      power_control  <= srcc_pkg::RST_POWER_CONTROL;
      clock_divider  <= srcc_pkg::RST_CLOCK_DIVIDER;
      aux_one        <= srcc_pkg::RST_AUX_ONE;
      clock_out_ctrl <= srcc_pkg::RST_CLOCK_OUT_CTRL;
    end else if (state != srcc_pkg::ST_RUN) begin
      power_control  <= srcc_pkg::RST_POWER_CONTROL;
      clock_divider  <= srcc_pkg::RST_CLOCK_DIVIDER;
      aux_one        <= srcc_pkg::RST_AUX_ONE;
      clock_out_ctrl <= srcc_pkg::RST_CLOCK_OUT_CTRL;
    end else if (sfr_write_ok) begin
      case (SFR_ADDR)
        srcc_pkg::ADDR_POWER_CONTROL:  power_control  <= SFR_WDATA;
        srcc_pkg::ADDR_CLOCK_DIVIDER:  clock_divider  <= SFR_WDATA;
        srcc_pkg::ADDR_AUX_ONE:        aux_one        <= SFR_WDATA;
        srcc_pkg::ADDR_CLOCK_OUT_CTRL: clock_out_ctrl <= SFR_WDATA;
        default: begin
        end
      endcase
    end
  end

  // Low-power bit registered once more from aux_one, held low outside run
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LOW_POWER_CLOCK <= 1'b0;
    end else begin
      LOW_POWER_CLOCK <= (state == srcc_pkg::ST_RUN) &&
                         aux_one[srcc_pkg::LOW_POWER_CLOCK_POS];
    end
  end

  // Divide ratio: zero means undivided, else twice the register value
  assign div_limit = (clock_divider == 8'h00) ? 9'h000 : {clock_divider, 1'b0} - 9'h001;

  // Divider counter compares with >= so a new ratio never stalls the core
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_cnt <= '0;
    end else if (state != srcc_pkg::ST_RUN) begin
      div_cnt <= '0;
    end else if (div_cnt >= div_limit) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 9'h001;
    end
  end

  assign core_clock_tick = (state == srcc_pkg::ST_RUN) && !any_reset && (div_cnt >= div_limit);

  // Core clock enable, gated off while held or waking
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CORE_CLOCK_EN <= 1'b0;
    end else begin
      CORE_CLOCK_EN <= core_clock_tick;
    end
  end

  // Clock output toggles on each core tick, giving core clock over two
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      DIVIDED_CLOCK_OUT <= 1'b0;
      DIVIDED_CLOCK_OE  <= 1'b0;
    end else if (clock_out_ctrl[srcc_pkg::CLOCK_OUTPUT_ENABLE_POS] && divided_clock_output_allowed &&
                 state == srcc_pkg::ST_RUN) begin
      DIVIDED_CLOCK_OE <= 1'b1;
      if (core_clock_tick) begin
        DIVIDED_CLOCK_OUT <= ~DIVIDED_CLOCK_OUT;
      end
    end else begin
      DIVIDED_CLOCK_OUT <= 1'b0;
      DIVIDED_CLOCK_OE  <= 1'b0;
    end
  end

  // Crystal port pins: input-only without pull-up during reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PORT3_INPUT_ONLY <= 1'b1;
      PORT3_PULLUP_EN  <= 1'b0;
    end else begin
      PORT3_INPUT_ONLY <= (state != srcc_pkg::ST_RUN);
      PORT3_PULLUP_EN  <= (state == srcc_pkg::ST_RUN);
    end
  end

  // Crystal input freed as a port for internal oscillators only
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CRYSTAL_INPUT_IS_PORT <= 1'b0;
    end else begin
      CRYSTAL_INPUT_IS_PORT <= ((CLOCK_SOURCE == srcc_pkg::CSRC_RC) ||
                                (CLOCK_SOURCE == srcc_pkg::CSRC_WDT_OSC)) &&
                               !TIMER_USES_CRYSTAL;
    end
  end

  // Registered read data, unmapped addresses read zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_RD) begin
      case (SFR_ADDR)
        srcc_pkg::ADDR_POWER_CONTROL:  SFR_RDATA <= power_control;
        srcc_pkg::ADDR_RESET_SOURCE:   SFR_RDATA <= {2'h0, reset_source};
        srcc_pkg::ADDR_CLOCK_DIVIDER:  SFR_RDATA <= clock_divider;
        srcc_pkg::ADDR_AUX_ONE:        SFR_RDATA <= aux_one;
        srcc_pkg::ADDR_CLOCK_OUT_CTRL: SFR_RDATA <= clock_out_ctrl;
        default:                       SFR_RDATA <= 8'h00;
      endcase
    end
  end

endmodule // srcc_top

// [srcc_pkg.sv]
// Constants for the system reset and core-clock control block
package srcc_pkg;

  // Special function register addresses
  localparam logic [7:0] ADDR_POWER_CONTROL   = 8'h87;
  localparam logic [7:0] ADDR_RESET_SOURCE    = 8'hdf;
  localparam logic [7:0] ADDR_CLOCK_DIVIDER   = 8'h95;
  localparam logic [7:0] ADDR_AUX_ONE         = 8'ha2;
  localparam logic [7:0] ADDR_CLOCK_OUT_CTRL  = 8'h96;

  // Register reset values
  localparam logic [7:0] RST_POWER_CONTROL    = 8'h00;
  localparam logic [7:0] RST_CLOCK_DIVIDER    = 8'h00;
  localparam logic [7:0] RST_AUX_ONE          = 8'h00;
  localparam logic [7:0] RST_CLOCK_OUT_CTRL   = 8'h00;

  // Reset source flag positions
  localparam int SRC_PIN       = 0;
  localparam int SRC_SOFTWARE  = 1;
  localparam int SRC_WATCHDOG  = 2;
  localparam int SRC_BREAK     = 3;
  localparam int SRC_BROWNOUT  = 4;
  localparam int SRC_POWER_ON  = 5;
  localparam int NUM_SOURCES   = 6;

  // Flags after power-on: power-on and brownout set, others clear
  localparam logic [5:0] RST_RESET_SOURCE     = 6'h30;

  // Field positions
  localparam int LOW_POWER_CLOCK_POS     = 7;
  localparam int CLOCK_OUTPUT_ENABLE_POS = 6;
  localparam int BOOT_STATUS_VECTOR_POS  = 0;

  // Clock and wake-up timing
  localparam int CLK_FREQ_HZ        = 10_000_000;
  localparam int WAKE_XTAL_CYCLES   = 992;
  localparam int WAKE_OTHER_CYCLES  = 224;
  localparam int WAKE_EXTRA_MIN_US  = 60;
  localparam int WAKE_EXTRA_CYCLES  = (WAKE_EXTRA_MIN_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int WAKE_XTAL_TOTAL    = WAKE_XTAL_CYCLES + WAKE_EXTRA_CYCLES;
  localparam int WAKE_OTHER_TOTAL   = WAKE_OTHER_CYCLES + WAKE_EXTRA_CYCLES;
  localparam int WAKE_CNT_W         = 11;

  // Fetch addresses
  localparam logic [15:0] FETCH_ZERO     = 16'h0000;
  localparam logic [7:0]  BOOT_LOW_BYTE  = 8'h00;

  // Oscillator source selection
  typedef enum logic [2:0] {
    CSRC_XTAL_LOW  = 3'h0,
    CSRC_XTAL_MED  = 3'h1,
    CSRC_XTAL_HIGH = 3'h2,
    CSRC_RC        = 3'h3,
    CSRC_WDT_OSC   = 3'h4,
    CSRC_EXTERNAL  = 3'h5
  } srcc_clk_src_t;

  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_WAKE  = 2'b01,
    ST_RUN   = 2'b10
  } srcc_state_t;

endpackage

// [srcc_properties.sv]
// Checker for reset holding, core clock gating, boot address and clock output
module srcc_properties #(
  parameter int WAKE_XTAL  = 8,
  parameter int WAKE_OTHER = 4
) (
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        WATCHDOG_TIMEOUT,
  input wire logic        SOFTWARE_RESET_REQ,
  input wire logic        BREAK_DETECT,
  input wire logic [2:0]  CLOCK_SOURCE,
  input wire logic        TIMER_USES_CRYSTAL,
  input wire logic [7:0]  BOOT_STATUS,
  input wire logic [7:0]  BOOT_VECTOR,
  input wire logic        CORE_RESET_N,
  input wire logic        CORE_CLOCK_EN,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic        LOW_POWER_CLOCK,
  input wire logic        DIVIDED_CLOCK_OE,
  input wire logic        PORT3_INPUT_ONLY,
  input wire logic        PORT3_PULLUP_EN
);
  logic [11:0] low_cnt;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Length of the current hold in reset and wake-up
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      low_cnt <= 12'h000;
    end else begin
      low_cnt <= CORE_RESET_N ? 12'h000 : low_cnt + 12'h001;
    end
  end
  property p_src_hold; (WATCHDOG_TIMEOUT || SOFTWARE_RESET_REQ || BREAK_DETECT) |-> ##2 !CORE_RESET_N; endproperty
  a_src_hold: assert property (p_src_hold) else $error("core not held in reset");
  property p_gate; !CORE_RESET_N && !$past(CORE_RESET_N) |-> !CORE_CLOCK_EN; endproperty
  a_gate: assert property (p_gate) else $error("core clock runs in reset");
  property p_lp; $rose(CORE_RESET_N) |-> !LOW_POWER_CLOCK; endproperty
  a_lp: assert property (p_lp) else $error("low power bit set after reset");
  property p_port; (WATCHDOG_TIMEOUT || SOFTWARE_RESET_REQ) |-> ##2 (PORT3_INPUT_ONLY && !PORT3_PULLUP_EN); endproperty
  a_port: assert property (p_port) else $error("crystal port not input only");
  property p_oe; DIVIDED_CLOCK_OE |-> $past(CLOCK_SOURCE) >= 3'h3 && !$past(TIMER_USES_CRYSTAL); endproperty
  a_oe: assert property (p_oe) else $error("clock output on crystal");
  property p_boot; $rose(CORE_RESET_N) && BOOT_STATUS[0] |-> FETCH_ADDR == {BOOT_VECTOR, 8'h00}; endproperty
  a_boot: assert property (p_boot) else $error("boot address wrong");
  property p_wake; $rose(CORE_RESET_N) |-> low_cnt >= ((CLOCK_SOURCE < 3'h3) ? WAKE_XTAL : WAKE_OTHER); endproperty
  a_wake: assert property (p_wake) else $error("wake-up delay too short");
  property p_pulse; CORE_RESET_N && CORE_CLOCK_EN |-> ##[1:511] (CORE_CLOCK_EN || !CORE_RESET_N); endproperty
  a_pulse: assert property (p_pulse) else $error("core clock stalled");
  c_boot: cover property ($rose(CORE_RESET_N) && BOOT_STATUS[0]);
  c_oe: cover property (DIVIDED_CLOCK_OE);
  c_lp: cover property (LOW_POWER_CLOCK);
endmodule // srcc_properties

bind srcc_top srcc_properties #(.WAKE_XTAL(WAKE_XTAL), .WAKE_OTHER(WAKE_OTHER)) i_srcc_properties (
  .CLK, .RSTN, .WATCHDOG_TIMEOUT, .SOFTWARE_RESET_REQ, .BREAK_DETECT, .CLOCK_SOURCE,
  .TIMER_USES_CRYSTAL, .BOOT_STATUS, .BOOT_VECTOR, .CORE_RESET_N, .CORE_CLOCK_EN, .FETCH_ADDR,
  .LOW_POWER_CLOCK, .DIVIDED_CLOCK_OE, .PORT3_INPUT_ONLY, .PORT3_PULLUP_EN
);

// [srcc_far_side.sv]
// Far-side model: pulled-up reset pin, brownout detector and core clock counter
module srcc_far_side (
  input  wire logic clk,
  input  wire logic pin_hold,
  input  wire logic brown_hold,
  input  wire logic core_clock_en,
  input  wire logic core_reset_n,
  output logic      rst_pin_n,
  output logic      brownout_det,
  output int        pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin rests high on its pull-up and is pulled low only on demand
  assign rst_pin_n = !pin_hold;
  assign brownout_det = brown_hold;
  // Core clock pulses seen by the running core
  initial pulses = 0;
  always @(posedge clk) begin
    if (core_reset_n && core_clock_en) begin
      pulses <= pulses + 1;
    end
  end
endmodule // srcc_far_side

// [testbench.sv]
// Self-checking testbench for the reset and core-clock control block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, RSTN, RST_PIN_N, BROWNOUT_DET, ISP_FORCE, WATCHDOG_TIMEOUT, SOFTWARE_RESET_REQ;
  logic BREAK_DETECT, RESET_PIN_ENABLE_BIT, TIMER_USES_CRYSTAL, SFR_WR, SFR_RD, CORE_RESET_N;
  logic CORE_CLOCK_EN, LOW_POWER_CLOCK, DIVIDED_CLOCK_OUT, DIVIDED_CLOCK_OE, CRYSTAL_INPUT_IS_PORT;
  logic PORT3_INPUT_ONLY, PORT3_PULLUP_EN, pin_hold, brown_hold, prev;
  logic [2:0]  CLOCK_SOURCE;
  logic [7:0]  BOOT_STATUS, BOOT_VECTOR, SFR_ADDR, SFR_WDATA, SFR_RDATA, exp;
  logic [15:0] FETCH_ADDR;
  int          failures, comparisons, pulses, n;
  int pos [5] = '{srcc_pkg::SRC_WATCHDOG, srcc_pkg::SRC_SOFTWARE, srcc_pkg::SRC_BREAK,
                  srcc_pkg::SRC_PIN, srcc_pkg::SRC_BROWNOUT};
  logic [7:0]  dv [3] = '{8'h03, 8'hff, 8'h00};
  logic [15:0] ep [3] = '{16'h00aa, 16'h0002, 16'h03fc};
  srcc_top #(.WAKE_XTAL(8), .WAKE_OTHER(4)) i_srcc_top (
    .CLK, .RSTN, .RST_PIN_N, .BROWNOUT_DET, .ISP_FORCE, .WATCHDOG_TIMEOUT, .SOFTWARE_RESET_REQ,
    .BREAK_DETECT, .RESET_PIN_ENABLE_BIT, .CLOCK_SOURCE, .TIMER_USES_CRYSTAL, .BOOT_STATUS,
    .BOOT_VECTOR, .SFR_ADDR, .SFR_WDATA, .SFR_WR, .SFR_RD, .SFR_RDATA, .CORE_RESET_N,
    .CORE_CLOCK_EN, .FETCH_ADDR, .LOW_POWER_CLOCK, .DIVIDED_CLOCK_OUT, .DIVIDED_CLOCK_OE,
    .CRYSTAL_INPUT_IS_PORT, .PORT3_INPUT_ONLY, .PORT3_PULLUP_EN
  );
  srcc_far_side i_srcc_far_side (
    .clk(CLK), .pin_hold, .brown_hold, .core_clock_en(CORE_CLOCK_EN),
    .core_reset_n(CORE_RESET_N), .rst_pin_n(RST_PIN_N), .brownout_det(BROWNOUT_DET), .pulses
  );
  // 10 MHz oscillator
  always #50 CLK = ~CLK;
  // Comparison and verdict
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    comparisons++;
    if (got !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Register accesses, driven on the falling edge
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1'b1;
    @(negedge CLK);
    SFR_WR = 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e, input string what);
    @(negedge CLK);
    SFR_ADDR = a;
    SFR_RD = 1'b1;
    @(negedge CLK);
    SFR_RD = 1'b0;
    chk(what, {8'h00, e}, {8'h00, SFR_RDATA});
  endtask
  // Bounded wait for the core to be released
  task automatic wait_run;
    n = 0;
    while (CORE_RESET_N !== 1'b1 && n < 3000) begin
      @(negedge CLK);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      test_done();
    end
  endtask
  // Raise one reset source for four cycles, then wait for the core
  task automatic kick(input int s);
    @(negedge CLK);
    case (s)
      0: WATCHDOG_TIMEOUT = 1'b1;
      1: SOFTWARE_RESET_REQ = 1'b1;
      2: BREAK_DETECT = 1'b1;
      3: pin_hold = 1'b1;
      default: brown_hold = 1'b1;
    endcase
    repeat (4) @(negedge CLK);
    {WATCHDOG_TIMEOUT, SOFTWARE_RESET_REQ, BREAK_DETECT, pin_hold, brown_hold} = 5'h00;
    repeat (4) @(negedge CLK);
    wait_run();
  endtask
  task automatic power_up;
    RSTN = 1'b0;
    repeat (3) @(negedge CLK);
    RSTN = 1'b1;
  endtask
  // Main sequence
  initial begin
    {CLK, RSTN, ISP_FORCE, WATCHDOG_TIMEOUT, SOFTWARE_RESET_REQ, BREAK_DETECT} = 6'h00;
    {TIMER_USES_CRYSTAL, SFR_WR, SFR_RD, pin_hold, brown_hold} = 5'h00;
    {failures, comparisons, SFR_ADDR, SFR_WDATA, BOOT_STATUS} = '0;
    RESET_PIN_ENABLE_BIT = 1'b1;
    CLOCK_SOURCE = 3'h3;
    BOOT_VECTOR = 8'h5a;
    power_up();
    wait_run();
    sfr_rd(8'hdf, 8'h30, "flags");
    chk("fetch", 16'h0000, FETCH_ADDR);
    sfr_rd(8'h87, 8'h00, "power_control");
    sfr_rd(8'h11, 8'h00, "unmapped");
    sfr_wr(8'h87, 8'ha5);
    sfr_rd(8'h87, 8'ha5, "power_control");
    sfr_wr(8'hdf, 8'hdf);
    sfr_rd(8'hdf, 8'h10, "flags");
    sfr_wr(8'hdf, 8'h00);
    exp = 8'h00;
    for (int s = 0; s < 5; s++) begin
      kick(s);
      exp = exp | (8'h01 << pos[s]);
      sfr_rd(8'hdf, exp, "flags");
    end
    chk("fetch", 16'h5a00, FETCH_ADDR);
    sfr_wr(8'hdf, 8'h00);
    kick(1);
    chk("fetch", 16'h0000, FETCH_ADDR);
    RESET_PIN_ENABLE_BIT = 1'b0;
    pin_hold = 1'b1;
    repeat (6) @(negedge CLK);
    chk("core_run", 16'h0001, {15'h0000, CORE_RESET_N});
    pin_hold = 1'b0;
    repeat (4) @(negedge CLK);
    sfr_rd(8'hdf, 8'h02, "flags");
    for (int i = 0; i < 3; i++) begin
      sfr_wr(8'h95, dv[i]);
      repeat (520) @(negedge CLK);
      n = pulses;
      repeat (1020) @(negedge CLK);
      chk("pulses", ep[i], 16'(pulses - n));
    end
    sfr_wr(8'h95, 8'h01);
    sfr_wr(8'ha2, 8'h80);
    sfr_rd(8'ha2, 8'h80, "aux_one");
    chk("low_power", 16'h0001, {15'h0000, LOW_POWER_CLOCK});
    kick(0);
    chk("low_power", 16'h0000, {15'h0000, LOW_POWER_CLOCK});
    sfr_rd(8'h95, 8'h00, "divider");
    chk("xtal_port", 16'h0001, {15'h0000, CRYSTAL_INPUT_IS_PORT});
    sfr_wr(8'h96, 8'h40);
    n = 0;
    for (int i = 0; i < 100; i++) begin
      prev = DIVIDED_CLOCK_OUT;
      @(negedge CLK);
      n += (DIVIDED_CLOCK_OUT !== prev);
    end
    chk("toggles", 16'h0064, 16'(n));
    chk("clock_oe", 16'h0001, {15'h0000, DIVIDED_CLOCK_OE});
    TIMER_USES_CRYSTAL = 1'b1;
    repeat (3) @(negedge CLK);
    chk("clock_oe", 16'h0000, {15'h0000, DIVIDED_CLOCK_OE});
    chk("xtal_port", 16'h0000, {15'h0000, CRYSTAL_INPUT_IS_PORT});
    TIMER_USES_CRYSTAL = 1'b0;
    CLOCK_SOURCE = 3'h0;
    BOOT_STATUS = 8'h01;
    kick(0);
    chk("fetch", 16'h5a00, FETCH_ADDR);
    BOOT_STATUS = 8'h00;
    ISP_FORCE = 1'b1;
    pin_hold = 1'b1;
    power_up();
    repeat (30) @(negedge CLK);
    chk("core_run", 16'h0000, {15'h0000, CORE_RESET_N});
    chk("port_input_only", 16'h0001, {15'h0000, PORT3_INPUT_ONLY});
    chk("port_pullup", 16'h0000, {15'h0000, PORT3_PULLUP_EN});
    pin_hold = 1'b0;
    wait_run();
    chk("fetch", 16'h5a00, FETCH_ADDR);
    test_done();
  end
endmodule // testbench
